// ==== rtl/temp_fmt_pkg.sv ====
// constants, register offsets and state codes for the temperature result formatter
// assumes a 40 MHz core clock and a power-up reset that drives rst_i high
package temp_fmt_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	// nominal external measurement time, 9.6 ms held in microseconds
	localparam int MEAS_TIME_US = 9600;
	localparam int MEAS_CYCLES = MEAS_TIME_US * (CLK_HZ / 1_000_000);
	localparam int MEAS_CNT_W = 19;

	// ==========================================================
	// data widths and averaging
	localparam int LOCAL_W = 10;
	localparam int REMOTE_W = 11;
	localparam int AVG_COUNT = 16;
	localparam int AVG_SHIFT = 4;
	localparam int AVG_CNT_W = 4;
	localparam int SUM_W = 15;
	localparam logic [AVG_CNT_W-1:0] AVG_LAST = 4'hF;

	// remote span limits, -127.000 and +127.750 in eighths of a degree
	localparam logic signed [REMOTE_W-1:0] REMOTE_MAX = 11'sh3FE;
	localparam logic signed [REMOTE_W-1:0] REMOTE_MIN = 11'sh408;

	// ==========================================================
	// registers
	localparam logic [7:0] REG_FRACTION_BITS = 8'h06;
	localparam logic [7:0] FRACTION_RESET = 8'h00;
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	localparam int FRAC_REMOTE_LSB = 5;
	localparam int FRAC_REMOTE_W = 3;
	localparam int FRAC_LOCAL_LSB = 3;
	localparam int FRAC_LOCAL_W = 2;

	// ==========================================================
	// slave address
	localparam logic [4:0] ADDR_FIXED = 5'h0B;
	localparam logic [1:0] ADDR_SEL_GND = 2'h0;
	localparam logic [1:0] ADDR_SEL_OPEN = 2'h2;
	localparam logic [1:0] ADDR_SEL_VCC = 2'h1;

	// ==========================================================
	// measurement sequencer
	typedef enum logic [1:0] {
		ST_ARMED = 2'b01,
		ST_BUSY = 2'b10
	} meas_state_t;
endpackage : temp_fmt_pkg

// ==== rtl/sample_if.sv ====
// carrier for one stream of remote samples between the formatter and its averager
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface sample_if;
	logic valid;
	logic signed [temp_fmt_pkg::REMOTE_W-1:0] data;
	modport src(output valid, output data);
	modport snk(input valid, input data);
endinterface : sample_if

// ==== rtl/remote_averager.sv ====
// running sum of sixteen remote samples, emits their mean as one pulse
// assumes the feeding side presents at most one sample per cycle
`timescale 1ns/100ps
module remote_averager (
	input wire logic clk_i,
	input wire logic rst_i,
	sample_if.snk raw,
	sample_if.src avg
);
	logic [temp_fmt_pkg::AVG_CNT_W-1:0] count;
	logic signed [temp_fmt_pkg::SUM_W-1:0] sum;
	logic signed [temp_fmt_pkg::SUM_W-1:0] next_sum;

	assign next_sum = sum + temp_fmt_pkg::SUM_W'(raw.data);

	// ==========================================================
	// accumulate
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count <= '0;
			sum <= '0;
		end
		else if (raw.valid)
		begin
			if (count == temp_fmt_pkg::AVG_LAST)
			begin
				count <= '0;
				sum <= '0;
			end
			else
			begin
				count <= count + 4'h1;
				sum <= next_sum;
			end
		end
	end

	// ==========================================================
	// mean out; the shift floors toward minus infinity, a bias of under one eighth degree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			avg.valid <= 1'b0;
			avg.data <= '0;
		end
		else
		begin
			avg.valid <= raw.valid && (count == temp_fmt_pkg::AVG_LAST);
			if (raw.valid && (count == temp_fmt_pkg::AVG_LAST))
			begin
				avg.data <= temp_fmt_pkg::REMOTE_W'(next_sum >>> temp_fmt_pkg::AVG_SHIFT);
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_avg_spacing: assert property (avg.valid |=> !avg.valid [*8])
		else $error("averaged result issued before sixteen samples");
	a_avg_needs_raw: assert property (avg.valid |-> $past(raw.valid) && $past(count) == 4'hF)
		else $error("averaged result without sixteenth sample");
endmodule : remote_averager

// ==== rtl/addr_strap.sv ====
// captures the three-state address select once, right after each reset on rst_i
// assumes the pad reports strong-low and strong-high levels; neither means open
`timescale 1ns/100ps
module addr_strap (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_low_i,
	input wire logic pin_high_i,
	output logic [1:0] addr_bits_o,
	output logic captured_o
);
	logic [1:0] decoded;

	always_comb
	begin
		// a pad that reports both levels is treated as floating
		if (pin_low_i && !pin_high_i)
			decoded = temp_fmt_pkg::ADDR_SEL_GND;
		else if (pin_high_i && !pin_low_i)
			decoded = temp_fmt_pkg::ADDR_SEL_VCC;
		else
			decoded = temp_fmt_pkg::ADDR_SEL_OPEN;
	end

	// ==========================================================
	// capture once; later pin changes are ignored until the next reset on rst_i
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			captured_o <= 1'b0;
			addr_bits_o <= temp_fmt_pkg::ADDR_SEL_OPEN;
		end
		else if (!captured_o)
		begin
			captured_o <= 1'b1;
			addr_bits_o <= decoded;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_strap_holds: assert property (captured_o |=> $stable(addr_bits_o) && captured_o)
		else $error("address bits changed after capture");
	a_strap_decode: assert property ($rose(captured_o) |-> addr_bits_o != 2'h3)
		else $error("address select decoded to an illegal code");
endmodule : addr_strap

// ==== rtl/temp_result_formatter.sv ====
// temperature result formatter: local and averaged remote results, fraction register, address
// assumes the ADC delivers one-cycle sample strobes synchronous to clk_i
`timescale 1ns/100ps
module temp_result_formatter #(
	parameter int MEAS_CYCLES = temp_fmt_pkg::MEAS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic local_valid_i,
	input wire logic [temp_fmt_pkg::LOCAL_W-1:0] local_sample_i,
	input wire logic remote_valid_i,
	input wire logic [temp_fmt_pkg::REMOTE_W-1:0] remote_sample_i,
	input wire logic addr_pin_low_i,
	input wire logic addr_pin_high_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	output logic remote_conv_start_o,
	output logic [7:0] local_temp_high_o,
	output logic [7:0] remote_temp_high_o,
	output logic [7:0] fraction_bits_o,
	output logic remote_update_o,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [6:0] slave_addr_o,
	output logic addr_ready_o
);
	localparam logic [temp_fmt_pkg::MEAS_CNT_W-1:0] TIMER_LAST =
		temp_fmt_pkg::MEAS_CNT_W'(MEAS_CYCLES - 1);

	temp_fmt_pkg::meas_state_t state;
	temp_fmt_pkg::meas_state_t next_state;
	logic [temp_fmt_pkg::MEAS_CNT_W-1:0] meas_timer;
	logic timer_wrap;
	logic signed [temp_fmt_pkg::REMOTE_W-1:0] remote_clamped;
	logic [1:0] strap_bits;
	logic strap_done;

	sample_if raw_if ();
	sample_if avg_if ();

	// ==========================================================
	// span limit for the averaged remote value
	function automatic logic signed [temp_fmt_pkg::REMOTE_W-1:0] clamp_remote(
		input logic signed [temp_fmt_pkg::REMOTE_W-1:0] v
	);
		if (v > temp_fmt_pkg::REMOTE_MAX)
			return temp_fmt_pkg::REMOTE_MAX;
		else if (v < temp_fmt_pkg::REMOTE_MIN)
			return temp_fmt_pkg::REMOTE_MIN;
		else
			return v;
	endfunction : clamp_remote

	// ==========================================================
	// measurement period timer
	assign timer_wrap = (meas_timer == TIMER_LAST);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			meas_timer <= '0;
		else if (timer_wrap)
			meas_timer <= '0;
		else
			meas_timer <= meas_timer + 19'h00001;
	end

	// ==========================================================
	// sequencer: one conversion request per period, a late answer costs a period
	always_comb
	begin
		next_state = state;
		unique case (state)
			temp_fmt_pkg::ST_ARMED:
			begin
				if (timer_wrap)
					next_state = temp_fmt_pkg::ST_BUSY;
			end
			temp_fmt_pkg::ST_BUSY:
			begin
				if (remote_valid_i)
					next_state = temp_fmt_pkg::ST_ARMED;
			end
			default:
			begin
				next_state = temp_fmt_pkg::ST_ARMED;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= temp_fmt_pkg::ST_ARMED;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			remote_conv_start_o <= 1'b0;
		else
			remote_conv_start_o <= timer_wrap && (state == temp_fmt_pkg::ST_ARMED);
	end

	// ==========================================================
	// remote samples: only answers to our own request reach the averager
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			raw_if.valid <= 1'b0;
			raw_if.data <= '0;
		end
		else
		begin
			raw_if.valid <= remote_valid_i && (state == temp_fmt_pkg::ST_BUSY);
			raw_if.data <= $signed(remote_sample_i);
		end
	end

	remote_averager u_avg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw(raw_if.snk),
		.avg(avg_if.src)
	);

	assign remote_clamped = clamp_remote(avg_if.data);

	// ==========================================================
	// result registers; both bytes of a channel move in one edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			remote_temp_high_o <= temp_fmt_pkg::TEMP_RESET;
		else if (avg_if.valid)
			remote_temp_high_o <= remote_clamped[10:3];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			local_temp_high_o <= temp_fmt_pkg::TEMP_RESET;
		else if (local_valid_i)
			local_temp_high_o <= local_sample_i[9:2];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fraction_bits_o <= temp_fmt_pkg::FRACTION_RESET;
		else
		begin
			if (avg_if.valid)
			begin
				fraction_bits_o[temp_fmt_pkg::FRAC_REMOTE_LSB +: temp_fmt_pkg::FRAC_REMOTE_W] <=
					remote_clamped[2:0];
			end
			if (local_valid_i)
			begin
				fraction_bits_o[temp_fmt_pkg::FRAC_LOCAL_LSB +: temp_fmt_pkg::FRAC_LOCAL_W] <=
					local_sample_i[1:0];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			remote_update_o <= 1'b0;
		else
			remote_update_o <= avg_if.valid;
	end

	// ==========================================================
	// register read port; a read in an update cycle returns the older value
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reg_rvalid_o <= 1'b0;
			reg_rdata_o <= temp_fmt_pkg::UNMAPPED_DATA;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i && (reg_addr_i == temp_fmt_pkg::REG_FRACTION_BITS))
				reg_rdata_o <= fraction_bits_o;
			else if (reg_rd_i)
				reg_rdata_o <= temp_fmt_pkg::UNMAPPED_DATA;
		end
	end

	// ==========================================================
	// slave address
	addr_strap u_strap (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_low_i(addr_pin_low_i),
		.pin_high_i(addr_pin_high_i),
		.addr_bits_o(strap_bits),
		.captured_o(strap_done)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			slave_addr_o <= {temp_fmt_pkg::ADDR_FIXED, temp_fmt_pkg::ADDR_SEL_OPEN};
			addr_ready_o <= 1'b0;
		end
		else
		begin
			slave_addr_o <= {temp_fmt_pkg::ADDR_FIXED, strap_bits};
			addr_ready_o <= strap_done;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [19:0] start_gap;
	logic start_seen;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_gap <= '0;
			start_seen <= 1'b0;
		end
		else if (remote_conv_start_o)
		begin
			start_gap <= '0;
			start_seen <= 1'b1;
		end
		else if (start_gap != 20'hFFFFF)
			start_gap <= start_gap + 20'h00001;
	end

	sequence s_read_frac;
		reg_rd_i && reg_addr_i == 8'h06;
	endsequence

	sequence s_read_answer;
		##1 reg_rvalid_o && reg_rdata_o == $past(fraction_bits_o);
	endsequence

	a_local_high: assert property (local_valid_i |=> local_temp_high_o == $past(local_sample_i[9:2]))
		else $error("local high byte is not the integer part of the sample");
	a_local_frac: assert property (local_valid_i |=> fraction_bits_o[4:3] == $past(local_sample_i[1:0]))
		else $error("local fraction bits do not match the sample");
	a_remote_together: assert property (!remote_update_o |-> $stable(remote_temp_high_o) && $stable(fraction_bits_o[7:5]))
		else $error("remote result moved without an update");
	a_remote_span: assert property ($signed({remote_temp_high_o, fraction_bits_o[7:5]}) <= 11'sh3FE)
		else $error("remote result above +127.75");
	a_period_grid: assert property (remote_conv_start_o && start_seen |-> ((int'(start_gap) + 1) % MEAS_CYCLES) == 0)
		else $error("conversion requests off the measurement period");
	a_raw_gated: assert property (raw_if.valid |-> $past(state) == temp_fmt_pkg::ST_BUSY)
		else $error("unrequested remote sample reached the averager");
	a_frac_read: assert property (s_read_frac |-> s_read_answer)
		else $error("fraction register read returned wrong data");
	a_addr_fixed: assert property (addr_ready_o |-> slave_addr_o[6:2] == 5'h0B && slave_addr_o[1:0] != 2'h3)
		else $error("slave address upper bits or select code wrong");

	// a mean leaves the averager, then both halves of the remote result show it one edge later
	sequence s_mean_out;
		avg_if.valid;
	endsequence

	sequence s_mean_shown;
		##1 remote_update_o && remote_temp_high_o == $past(remote_clamped[10:3])
			&& fraction_bits_o[7:5] == $past(remote_clamped[2:0]);
	endsequence

	a_mean_shown: assert property (s_mean_out |-> s_mean_shown)
		else $error("remote high byte and fraction not taken from one mean");
	a_start_waits: assert property (remote_conv_start_o |-> state == temp_fmt_pkg::ST_BUSY)
		else $error("conversion request without waiting for its answer");
	a_update_single: assert property (remote_update_o |=> !remote_update_o [*8])
		else $error("remote update pulses too close together");
endmodule : temp_result_formatter

// ==== dv/remote_adc_model.sv ====
// behavioural remote converter: answers each conversion request with one 11-bit sample
// assumes start_i is a one-cycle pulse synchronous to clk_i
`timescale 1ns/100ps
module remote_adc_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [10:0] base_i,
	input wire logic [10:0] step_i,
	output logic valid_o,
	output logic [10:0] data_o
);
	// ==========================================================
	// answer sequencing
	logic busy;
	logic [4:0] wait_cnt;
	logic [3:0] n_done;
	logic [10:0] held;

	// latency runs two prompt then two slow answers so both reach the averager
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			busy <= 1'b0;
			wait_cnt <= 5'h00;
			n_done <= 4'h0;
			valid_o <= 1'b0;
			held <= 11'h000;
		end
		else
		begin
			valid_o <= 1'b0;
			if (start_i)
			begin
				busy <= 1'b1;
				wait_cnt <= n_done[1] ? 5'h14 : 5'h01;
			end
			else if (busy && wait_cnt == 5'h01)
			begin
				busy <= 1'b0;
				valid_o <= 1'b1;
				held <= base_i + (n_done[0] ? step_i : 11'h000);
				n_done <= n_done + 4'h1;
			end
			else if (busy)
			begin
				wait_cnt <= wait_cnt - 5'h01;
			end
		end
	end

	// outside a strobe the bus shows the inverse, never a stale value
	assign data_o = valid_o ? held : ~held;
endmodule : remote_adc_model

// ==== dv/tb.sv ====
// self-checking bench for the temperature result formatter
// assumes a shortened measurement period of 64 cycles
`timescale 1ns/100ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic local_valid_i = 1'b0;
	logic [9:0] local_sample_i = 10'h000;
	logic pin_low = 1'b0;
	logic pin_high = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [10:0] base = 11'h000;
	logic [10:0] step = 11'h000;
	logic remote_valid, conv_start, remote_update_o, reg_rvalid_o, addr_ready_o;
	logic [10:0] remote_data;
	logic [7:0] local_temp_high_o, remote_temp_high_o, fraction_bits_o, reg_rdata_o;
	logic [6:0] slave_addr_o;
	logic [7:0] d;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;

	temp_result_formatter #(.MEAS_CYCLES(64)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.local_valid_i(local_valid_i), .local_sample_i(local_sample_i),
		.remote_valid_i(remote_valid), .remote_sample_i(remote_data),
		.addr_pin_low_i(pin_low), .addr_pin_high_i(pin_high), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .remote_conv_start_o(conv_start),
		.local_temp_high_o(local_temp_high_o), .remote_temp_high_o(remote_temp_high_o),
		.fraction_bits_o(fraction_bits_o), .remote_update_o(remote_update_o),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.slave_addr_o(slave_addr_o), .addr_ready_o(addr_ready_o));

	remote_adc_model adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start), .base_i(base),
		.step_i(step), .valid_o(remote_valid), .data_o(remote_data));

	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end

	// ==========================================================
	// shared tasks
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// hang guard, generous against about 10300 cycles of tests
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test;
		end
	end

	task automatic do_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : do_reset

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		int i;
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		check("read valid", {7'h00, reg_rvalid_o}, 8'h01);
		q = reg_rdata_o;
	endtask : rd

	task automatic strap_case(input logic lo, input logic hi, input logic [6:0] exp);
		@(posedge clk_i);
		pin_low <= lo;
		pin_high <= hi;
		do_reset;
		check("slave addr", {1'b0, slave_addr_o}, {1'b0, exp});
		check("addr ready", {7'h00, addr_ready_o}, 8'h01);
		@(posedge clk_i);
		pin_low <= ~lo;
		pin_high <= ~hi;
		repeat (5) @(posedge clk_i);
		#1;
		check("addr held", {1'b0, slave_addr_o}, {1'b0, exp});
	endtask : strap_case

	task automatic local_case(input logic [9:0] v, input logic [7:0] h, input logic [1:0] f);
		@(posedge clk_i);
		local_valid_i <= 1'b1;
		local_sample_i <= v;
		@(posedge clk_i);
		local_valid_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("local high", local_temp_high_o, h);
		rd(8'h06, d);
		check("local frac", d, {3'h0, f, 3'h0});
	endtask : local_case

	task automatic wait_update;
		int i;
		@(posedge clk_i);
		#1;
		for (i = 0; i < 1500 && remote_update_o !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		check("update", {7'h00, remote_update_o}, 8'h01);
	endtask : wait_update

	// two consecutive conversion requests must sit one measurement period apart
	task automatic period_case;
		int i;
		int t0;
		for (i = 0; i < 200 && conv_start !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		t0 = cyc;
		@(posedge clk_i);
		#1;
		for (i = 0; i < 200 && conv_start !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		check("start gap", 8'(cyc - t0), 8'h40);
	endtask : period_case

	// the first mean after a change mixes old and new samples, so judge the second
	task automatic remote_case(input logic [10:0] b, input logic [10:0] s,
		input logic [7:0] h, input logic [2:0] f);
		@(posedge clk_i);
		base <= b;
		step <= s;
		wait_update;
		wait_update;
		check("remote high", remote_temp_high_o, h);
		check("remote frac", fraction_bits_o, {f, 2'h2, 3'h0});
		rd(8'h06, d);
		check("frac reg", d, {f, 2'h2, 3'h0});
	endtask : remote_case

	// ==========================================================
	// test sequence
	initial
	begin
		strap_case(1'b1, 1'b0, 7'h2C);
		strap_case(1'b0, 1'b1, 7'h2D);
		strap_case(1'b1, 1'b1, 7'h2E);
		strap_case(1'b0, 1'b0, 7'h2E);
		rd(8'h06, d);
		check("frac reset", d, 8'h00);
		local_case(10'h39C, 8'hE7, 2'h0);
		local_case(10'h02B, 8'h0A, 2'h3);
		local_case(10'h201, 8'h80, 2'h1);
		local_case(10'h1FE, 8'h7F, 2'h2);
		rd(8'h05, d);
		check("unmapped", d, 8'h00);
		period_case;
		remote_case(11'h050, 11'h008, 8'h0A, 3'h4);
		remote_case(11'h737, 11'h008, 8'hE7, 3'h3);
		remote_case(11'h737, 11'h001, 8'hE6, 3'h7);
		remote_case(11'h3FF, 11'h000, 8'h7F, 3'h6);
		remote_case(11'h400, 11'h000, 8'h81, 3'h0);
		stop_test;
	end
endmodule : tb
